//--- src/mode_sequencer.sv
// Instrument mode and safety sequencer with APB register port.
// Assumes msg_valid/msg_code come from pclk-domain bus logic; the
// watchdog and detector pulse inputs are asynchronous pins.
//
// Functional notes
// - Four modes, exactly one active
// - Slit, detector, HV, angle set in any mode
// - Power-on and watchdog reset enter maintenance
// - Maintenance left only by command or by yaw end
// - Maintenance enables upload, reprogram and dump
// - Test mode outputs raw pulse heights
// - Imaging frame every 15 s, 191x14x5
// - Bands come from uploadable band table
// - Spectrograph: fixed angle within 140 degrees
// - Yaw start: HV off, stow, maintenance
// - Yaw end restores previous mode
// - Panel maneuver sets flag, mode unchanged
// - Terminator sets flag, mode and slit unchanged
// - Power warning: exit, HV off, stow within 2 s
// - Excess count rate: HV off, stow, maintenance
// - Sun event holds safe until ground command; a settings write during the hold still unstows the mirror
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module mode_sequencer #(
    parameter longint IMG_CYC = mode_seq_pkg::IMG_PERIOD_CYC,
    parameter longint SPEC_CYC = mode_seq_pkg::SPEC_PERIOD_CYC,
    parameter int RATE_WIN_CYC = int'(mode_seq_pkg::RATE_WINDOW_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic msg_valid,
    input wire logic [2:0] msg_code,
    input wire logic wdog_reset_pin,
    input wire logic det_pulse_pin,
    output logic [1:0] mode_out,
    output logic hv_on,
    output logic [7:0] hv_level,
    output logic mirror_stowed,
    output logic [7:0] mirror_angle,
    output logic [1:0] slit_pos,
    output logic det_sel,
    output logic upload_en,
    output logic raw_out_sel,
    output logic frame_strobe,
    output logic frame_spectral,
    output logic [39:0] frame_bands,
    output logic panel_flag,
    output logic term_flag
);
    // =====================================================================
    // Input synchronisers and rate monitor
    // =====================================================================
    logic [1:0] wd_sync_q, det_sync_q;   // Two-flop chains
    logic wd_prev_q;                     // Watchdog edge history
    logic sun_evt;                       // One-cycle overrate event

    // Pin synchronisers; only the second stage is read downstream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_sync_q <= 2'b00;
            det_sync_q <= 2'b00;
            wd_prev_q <= 1'b0;
        end else begin
            wd_sync_q <= {wd_sync_q[0], wdog_reset_pin};
            det_sync_q <= {det_sync_q[0], det_pulse_pin};
            wd_prev_q <= wd_sync_q[1];
        end
    end

    logic wd_evt;
    assign wd_evt = wd_sync_q[1] && !wd_prev_q;

    logic [15:0] rate_limit_q, rate_limit_d;   // Max counts per window

    rate_monitor #(.WINDOW_CYC(RATE_WIN_CYC)) u_rate (
        .pclk(pclk),
        .presetn(presetn),
        .pulse_sync(det_sync_q[1]),
        .limit(rate_limit_q),
        .over_q(sun_evt)
    );

    // =====================================================================
    // APB decode
    // =====================================================================
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic setup, wr_acc;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;

    logic cmd_wr, set_wr, stat_wr;
    assign cmd_wr = wr_acc && hit(paddr, mode_seq_pkg::OFS_MODE_CMD);
    assign set_wr = wr_acc && hit(paddr, mode_seq_pkg::OFS_SETTINGS);
    assign stat_wr = wr_acc && hit(paddr, mode_seq_pkg::OFS_STATUS);

    logic msg_yaw_s, msg_yaw_e, msg_pan_s, msg_pan_e, msg_term, msg_pd;
    assign msg_yaw_s = msg_valid && msg_code == mode_seq_pkg::MSG_YAW_START;
    assign msg_yaw_e = msg_valid && msg_code == mode_seq_pkg::MSG_YAW_END;
    assign msg_pan_s = msg_valid && msg_code == mode_seq_pkg::MSG_PANEL_START;
    assign msg_pan_e = msg_valid && msg_code == mode_seq_pkg::MSG_PANEL_END;
    assign msg_term = msg_valid && msg_code == mode_seq_pkg::MSG_TERMINATOR;
    assign msg_pd = msg_valid && msg_code == mode_seq_pkg::MSG_POWER_DOWN;

    // =====================================================================
    // Mode and safety state
    // =====================================================================
    mode_seq_pkg::op_mode_e mode_q, mode_d, prev_q, prev_d;
    logic yaw_q, yaw_d;        // Yaw maneuver in progress
    logic sun_q, sun_d;        // Sun safe hold
    logic pd_q, pd_d;          // Power-down warning seen
    logic pan_q, pan_d;
    logic trm_q, trm_d;
    logic hv_q, hv_d;
    logic stow_q, stow_d;
    logic [7:0] hvl_q, hvl_d, ang_q, ang_d;
    logic [1:0] slit_q, slit_d;
    logic det_q, det_d;
    logic [7:0] band_q [mode_seq_pkg::NUM_BANDS];
    logic [7:0] band_d [mode_seq_pkg::NUM_BANDS];
    logic [7:0] req_ang;

    // Next values; safety events are applied last so they win
    always_comb begin
        mode_d = mode_q;
        prev_d = prev_q;
        yaw_d = yaw_q;
        sun_d = sun_q;
        pd_d = pd_q;
        pan_d = pan_q;
        trm_d = trm_q;
        hv_d = hv_q;
        stow_d = stow_q;
        hvl_d = hvl_q;
        ang_d = ang_q;
        slit_d = slit_q;
        det_d = det_q;
        rate_limit_d = rate_limit_q;
        band_d = band_q;
        req_ang = pwdata[mode_seq_pkg::SET_ANGLE_LSB +: 8];
        // Ground mode command; with yaw end, the only way out of maintenance
        if (cmd_wr) begin
            mode_d = mode_seq_pkg::op_mode_e'(pwdata[1:0]);
            sun_d = 1'b0;
            pd_d = 1'b0;
        end
        // Settings apply in any mode
        if (set_wr) begin
            slit_d = pwdata[mode_seq_pkg::SET_SLIT_LSB +: 2];
            det_d = pwdata[mode_seq_pkg::SET_DET_BIT];
            hvl_d = pwdata[mode_seq_pkg::SET_HV_LSB +: 8];
            // HV stays off while a safe hold is in force
            hv_d = pwdata[mode_seq_pkg::SET_HV_EN_BIT] && !sun_d && !pd_d;
            // Angle clamped to the field of regard
            ang_d = (req_ang > mode_seq_pkg::ANGLE_MAX_DEG) ? mode_seq_pkg::ANGLE_MAX_DEG : req_ang;
            stow_d = 1'b0;
        end
        if (wr_acc && hit(paddr, mode_seq_pkg::OFS_RATE_LIMIT)) begin
            rate_limit_d = pwdata[15:0];
        end
        for (int i = 0; i < mode_seq_pkg::NUM_BANDS; i++) begin
            if (wr_acc && hit(paddr, mode_seq_pkg::OFS_BAND0 + 8'(4 * i))) begin
                band_d[i] = pwdata[7:0];
            end
        end
        // Terminator flag: write one clears, a new crossing wins
        if (stat_wr && pwdata[mode_seq_pkg::ST_TERM_BIT]) begin
            trm_d = 1'b0;
        end
        if (msg_term) begin
            trm_d = 1'b1;
        end
        if (msg_pan_s) begin
            pan_d = 1'b1;
        end else if (msg_pan_e) begin
            pan_d = 1'b0;
        end
        if (msg_yaw_s && !yaw_q) begin
            prev_d = cmd_wr ? mode_d : mode_q;
            yaw_d = 1'b1;
            mode_d = mode_seq_pkg::MODE_MAINT;
            hv_d = 1'b0;
            stow_d = 1'b1;
        end else if (msg_yaw_e && yaw_q) begin
            yaw_d = 1'b0;
            // Sun hold blocks the automatic return
            if (!sun_d) begin
                mode_d = prev_q;
            end
        end
        if (msg_pd) begin
            pd_d = 1'b1;
            mode_d = mode_seq_pkg::MODE_MAINT;
            hv_d = 1'b0;
            stow_d = 1'b1;
        end
        if (sun_evt) begin
            sun_d = 1'b1;
            mode_d = mode_seq_pkg::MODE_MAINT;
            hv_d = 1'b0;
            stow_d = 1'b1;
        end
        if (wd_evt) begin
            mode_d = mode_seq_pkg::MODE_MAINT;
        end
    end

    // State registers; power-on lands in maintenance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= mode_seq_pkg::MODE_MAINT;
            prev_q <= mode_seq_pkg::MODE_MAINT;
            {yaw_q, sun_q, pd_q, pan_q, trm_q, hv_q, det_q} <= 7'h00;
            stow_q <= 1'b1;
            hvl_q <= 8'h00;
            ang_q <= 8'h00;
            slit_q <= 2'h0;
            rate_limit_q <= mode_seq_pkg::RATE_LIMIT_RST;
            for (int i = 0; i < mode_seq_pkg::NUM_BANDS; i++) begin
                band_q[i] <= mode_seq_pkg::BAND_RST;
            end
        end else begin
            mode_q <= mode_d;
            prev_q <= prev_d;
            {yaw_q, sun_q, pd_q, pan_q, trm_q, hv_q, det_q} <= {yaw_d, sun_d, pd_d, pan_d, trm_d, hv_d, det_d};
            stow_q <= stow_d;
            hvl_q <= hvl_d;
            ang_q <= ang_d;
            slit_q <= slit_d;
            rate_limit_q <= rate_limit_d;
            band_q <= band_d;
        end
    end

    // =====================================================================
    // Frame timing
    // =====================================================================
    logic [31:0] fcnt_q, fcnt_d;
    logic fstb_d, fspec_d;
    logic [39:0] fband_q, fband_d;

    // Period counter restarts on every mode change
    always_comb begin
        fcnt_d = fcnt_q + 32'h1;
        fstb_d = 1'b0;
        fspec_d = frame_spectral;
        fband_d = fband_q;
        if (mode_d != mode_q || mode_q == mode_seq_pkg::MODE_MAINT || mode_q == mode_seq_pkg::MODE_TEST) begin
            fcnt_d = 32'h0;
        end else if (mode_q == mode_seq_pkg::MODE_IMAGING && fcnt_q >= 32'(IMG_CYC - 1)) begin
            fcnt_d = 32'h0;
            fstb_d = 1'b1;
            fspec_d = 1'b0;
            // Table sampled per frame, so a new upload hits later frames
            fband_d = {band_q[4], band_q[3], band_q[2], band_q[1], band_q[0]};
        end else if (mode_q == mode_seq_pkg::MODE_SPECTRO && fcnt_q >= 32'(SPEC_CYC - 1)) begin
            fcnt_d = 32'h0;
            fstb_d = 1'b1;
            fspec_d = 1'b1;
        end
    end

    // Frame registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_q <= 32'h0;
            frame_strobe <= 1'b0;
            frame_spectral <= 1'b0;
            fband_q <= 40'h0;
        end else begin
            fcnt_q <= fcnt_d;
            frame_strobe <= fstb_d;
            frame_spectral <= fspec_d;
            fband_q <= fband_d;
        end
    end

    // =====================================================================
    // APB answer: zero wait states, registered
    // =====================================================================
    logic [31:0] rd_d;
    logic err_d;

    // Read data and error chosen in the setup cycle
    always_comb begin
        rd_d = 32'h0;
        err_d = 1'b0;
        unique case (paddr)
            mode_seq_pkg::OFS_MODE_CMD: rd_d = {30'h0, mode_q};
            mode_seq_pkg::OFS_SETTINGS: rd_d = {12'h0, ang_q, hvl_q, hv_q, det_q, slit_q};
            mode_seq_pkg::OFS_RATE_LIMIT: rd_d = {16'h0, rate_limit_q};
            mode_seq_pkg::OFS_STATUS: rd_d = {21'h0, pd_q, stow_q, hv_q, trm_q, pan_q, sun_q, yaw_q, prev_q, mode_q};
            8'h10, 8'h14, 8'h18, 8'h1C, 8'h20: rd_d = {24'h0, band_q[3'(paddr[5:2] - 4'h4)]};
            default: err_d = 1'b1;
        endcase
    end

    // Outputs registered straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && err_d;
            prdata <= setup ? rd_d : 32'h0;
        end
    end

    // Registered mirrors of the state for the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upload_en <= 1'b1;
            raw_out_sel <= 1'b0;
        end else begin
            upload_en <= mode_d == mode_seq_pkg::MODE_MAINT;
            raw_out_sel <= mode_d == mode_seq_pkg::MODE_TEST;
        end
    end

    assign mode_out = mode_q;
    assign hv_on = hv_q;
    assign hv_level = hvl_q;
    assign mirror_stowed = stow_q;
    assign mirror_angle = ang_q;
    assign slit_pos = slit_q;
    assign det_sel = det_q;
    assign panel_flag = pan_q;
    assign term_flag = trm_q;
    assign frame_bands = fband_q;

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_safe;
        mode_q == mode_seq_pkg::MODE_MAINT && !hv_q && stow_q;
    endsequence

    property p_yaw_safe;
        msg_yaw_s && !yaw_q |=> s_safe ##0 yaw_q && prev_q == $past(cmd_wr ? pwdata[1:0] : mode_q);
    endproperty
    a_yaw_safe: assert property (p_yaw_safe) else $error("yaw start not safed");

    property p_yaw_end;
        msg_yaw_e && yaw_q && !sun_evt && !sun_q && !cmd_wr && !msg_pd && !wd_evt |=> mode_q == $past(prev_q);
    endproperty
    a_yaw_end: assert property (p_yaw_end) else $error("yaw end did not restore");

    property p_panel;
        msg_pan_s && !cmd_wr && !sun_evt && !wd_evt |=> pan_q && $stable(mode_q);
    endproperty
    a_panel: assert property (p_panel) else $error("panel flag wrong");

    property p_term;
        msg_term && !cmd_wr && !set_wr && !sun_evt && !wd_evt |=> trm_q && $stable(mode_q) && $stable(slit_q);
    endproperty
    a_term: assert property (p_term) else $error("terminator handling wrong");

    property p_pd;
        msg_pd |-> ##[1:2] s_safe;
    endproperty
    a_pd: assert property (p_pd) else $error("power down not safed");

    property p_sun;
        sun_evt |=> s_safe ##1 sun_q [*2];
    endproperty
    a_sun: assert property (p_sun) else $error("overrate not safed");

    property p_hold;
        sun_q && !cmd_wr |=> mode_q == mode_seq_pkg::MODE_MAINT && sun_q;
    endproperty
    a_hold: assert property (p_hold) else $error("sun hold released");

    property p_maint_stay;
        mode_q == mode_seq_pkg::MODE_MAINT && !cmd_wr && !(msg_yaw_e && yaw_q) |=> mode_q == mode_seq_pkg::MODE_MAINT;
    endproperty
    a_maint_stay: assert property (p_maint_stay) else $error("left maintenance alone");

    property p_wdog;
        wd_evt |=> mode_q == mode_seq_pkg::MODE_MAINT ##1 upload_en;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog did not enter maintenance");

    property p_raw;
        raw_out_sel == (mode_q == mode_seq_pkg::MODE_TEST) && upload_en == (mode_q == mode_seq_pkg::MODE_MAINT);
    endproperty
    a_raw: assert property (p_raw) else $error("mode outputs disagree");

    property p_frame;
        frame_strobe |-> $past(mode_q) inside {mode_seq_pkg::MODE_IMAGING, mode_seq_pkg::MODE_SPECTRO} && mirror_angle <= 8'h8C;
    endproperty
    a_frame: assert property (p_frame) else $error("frame outside scan mode");

endmodule
`default_nettype wire

//--- src/mode_seq_pkg.sv
// Package for the instrument mode and safety sequencer.
// Assumes a 100 MHz pclk and an APB register port with 32-bit data.
package mode_seq_pkg;

    // =====================================================================
    // Operating modes
    // =====================================================================
    typedef enum logic [1:0] {
        MODE_MAINT = 2'b00,     // Safe mode, uploads allowed
        MODE_TEST = 2'b01,      // Raw pulse height samples
        MODE_IMAGING = 2'b10,   // Five-band line scan frames
        MODE_SPECTRO = 2'b11    // Fixed mirror focal plane frames
    } op_mode_e;

    // =====================================================================
    // Status message codes from the spacecraft_command_data_handler
    // =====================================================================
    localparam logic [2:0] MSG_YAW_START = 3'h0;
    localparam logic [2:0] MSG_YAW_END = 3'h1;
    localparam logic [2:0] MSG_PANEL_START = 3'h2;
    localparam logic [2:0] MSG_PANEL_END = 3'h3;
    localparam logic [2:0] MSG_TERMINATOR = 3'h4;
    localparam logic [2:0] MSG_POWER_DOWN = 3'h5;

    // =====================================================================
    // Register offsets (byte addresses)
    // =====================================================================
    localparam logic [7:0] OFS_MODE_CMD = 8'h00;
    localparam logic [7:0] OFS_SETTINGS = 8'h04;
    localparam logic [7:0] OFS_RATE_LIMIT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_BAND0 = 8'h10;
    localparam int NUM_BANDS = 5;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int SET_SLIT_LSB = 0;     // [1:0] slit position
    localparam int SET_DET_BIT = 2;      // Detector select
    localparam int SET_HV_EN_BIT = 3;    // High voltage request
    localparam int SET_HV_LSB = 4;       // [11:4] high voltage level
    localparam int SET_ANGLE_LSB = 12;   // [19:12] mirror angle, degrees
    localparam int ST_TERM_BIT = 7;      // Terminator flag, write one clears

    // =====================================================================
    // Reset values and limits
    // =====================================================================
    localparam logic [15:0] RATE_LIMIT_RST = 16'hFFFF;
    localparam logic [7:0] ANGLE_MAX_DEG = 8'h8C;   // 140 degree field
    localparam logic [7:0] BAND_RST = 8'h00;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam longint CLK_HZ = 100_000_000;
    localparam longint IMG_PERIOD_S = 15;
    localparam longint SPEC_PERIOD_S = 3;
    localparam longint PD_LIMIT_S = 2;
    localparam longint IMG_PERIOD_CYC = IMG_PERIOD_S * CLK_HZ;
    localparam longint SPEC_PERIOD_CYC = SPEC_PERIOD_S * CLK_HZ;
    localparam longint PD_LIMIT_CYC = PD_LIMIT_S * CLK_HZ;
    localparam longint RATE_WINDOW_CYC = 100_000;   // 1 ms gate
    localparam int IMG_COLS = 191;
    localparam int IMG_ROWS = 14;
    localparam int SPEC_BINS = 168;

endpackage

//--- src/rate_monitor.sv
// Detector count rate monitor: counts pulse edges per gate window.
// Assumes the pulse input is already synchronised to pclk.
`timescale 1ns/100ps
`default_nettype none
module rate_monitor #(
    parameter int WINDOW_CYC = 100_000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pulse_sync,
    input wire logic [15:0] limit,
    output logic over_q
);
    // =====================================================================
    // Edge detect and window counting
    // =====================================================================
    logic prev_q, prev_d;          // Last synced level
    logic [31:0] win_q, win_d;     // Gate window timer
    logic [16:0] cnt_q, cnt_d;     // Edges seen in window, saturating
    logic over_d;

    // Next state: count rising edges, flag when past limit
    always_comb begin
        prev_d = pulse_sync;
        over_d = 1'b0;
        cnt_d = cnt_q;
        win_d = win_q + 32'h1;
        if (pulse_sync && !prev_q && !cnt_q[16]) begin
            cnt_d = cnt_q + 17'h1;
        end
        if ({1'b0, limit} < cnt_q) begin
            // Report once, then restart to avoid a stuck flag
            over_d = 1'b1;
            cnt_d = 17'h0;
        end
        if (win_q >= 32'(WINDOW_CYC - 1)) begin
            win_d = 32'h0;
            cnt_d = 17'h0;
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
            win_q <= 32'h0;
            cnt_q <= 17'h0;
            over_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            win_q <= win_d;
            cnt_q <= cnt_d;
            over_q <= over_d;
        end
    end
endmodule
`default_nettype wire

//--- tb/cdh_model.sv
// Model of the spacecraft command and data handling side of the bus.
// Assumes its send task is called just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module cdh_model (
    input wire logic pclk,
    output logic msg_valid,
    output logic [2:0] msg_code
);
    // ==========================================================
    // Idle state: no strobe, code scrambled so stale codes never pass
    // ==========================================================
    initial begin
        msg_valid = 1'b0;
        msg_code = 3'h7;
    end
    // One-cycle status broadcast, then the code is inverted
    task send(input logic [2:0] c);
        msg_valid <= 1'b1;
        msg_code <= c;
        @(posedge pclk);
        msg_valid <= 1'b0;
        msg_code <= ~c;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the mode and safety sequencer.
// Assumes the zero-wait-state APB port and the cdh_model partner.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic wdog_pin = 1'b0, det_pin = 1'b0; // Asynchronous pins
    logic [7:0] paddr = 8'h00, hv_level, angle;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, s, b;
    logic [31:0] seed = 32'h0000D648; // Fixed seed for repeatable runs
    logic pready, pslverr, er, msg_valid, hv_on, stowed, upl, raw, panel, term, dsel;
    logic [2:0] msg_code;
    logic [1:0] mode, slit;
    logic fstb, fspec; // Frame strobe and kind
    logic [39:0] fbands; // Band snapshot per imaging frame
    int n_mismatch = 0, check_count = 0;
    // Short frame and gate counts keep the run brief
    mode_sequencer #(.IMG_CYC(20), .SPEC_CYC(12), .RATE_WIN_CYC(16)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg_code(msg_code),
        .wdog_reset_pin(wdog_pin), .det_pulse_pin(det_pin), .mode_out(mode), .hv_on(hv_on),
        .hv_level(hv_level), .mirror_stowed(stowed), .mirror_angle(angle), .slit_pos(slit), .det_sel(dsel),
        .upload_en(upl), .raw_out_sel(raw), .frame_strobe(fstb), .frame_spectral(fspec), .frame_bands(fbands),
        .panel_flag(panel), .term_flag(term));
    cdh_model cdh (.pclk(pclk), .msg_valid(msg_valid), .msg_code(msg_code));
    // ==========================================================
    // Clock and helpers
    // ==========================================================
    always #5 pclk = ~pclk;
    // Xorshift generator
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Mirror angle is clamped to the field of regard
    function automatic logic [7:0] exp_angle(input logic [7:0] a);
        return (a > mode_seq_pkg::ANGLE_MAX_DEG) ? mode_seq_pkg::ANGLE_MAX_DEG : a;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; answer taken at the edge where pready is high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        // Answer taken at the same edge that sees pready high
        rd = prdata;
        er = pslverr;
        if (n == 50) begin
            n_mismatch++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Bounded wait for a mode, sampled at mid-cycle, then realign to the rising edge
    task automatic wait_mode(input logic [1:0] m);
        int n;
        for (n = 0; n < 100 && mode !== m; n++) @(negedge pclk);
        chk(mode, m);
        if (n == 100) conclude();
        @(posedge pclk);
    endtask
    // Bounded wait for a frame strobe, sampled at the clock edge
    task automatic wait_frame(input logic spec);
        int n;
        for (n = 0; n < 100 && fstb !== 1'b1; n++) @(posedge pclk);
        chk(fspec, spec);
        if (n == 100) begin
            n_mismatch++;
            conclude();
        end
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({mode, hv_on, stowed, upl}, {2'h0, 1'b0, 1'b1, 1'b1});
        @(posedge pclk);
        s = (rnd() & 32'h000FFFFF) | 32'h00000008;
        apb(1'b1, mode_seq_pkg::OFS_SETTINGS, s);
        chk({slit, dsel, hv_on, hv_level, angle, stowed}, {s[1:0], s[2], 1'b1, s[11:4], exp_angle(s[19:12]), 1'b0});
        chk(mode, 2'h0);
        b = rnd();
        // One small table upload, well inside the daily allowance
        apb(1'b1, mode_seq_pkg::OFS_BAND0 + 8'h08, b);
        apb(1'b1, mode_seq_pkg::OFS_MODE_CMD, 32'h00000002);
        chk({mode, upl}, {2'h2, 1'b0});
        wait_frame(1'b0);
        chk(fbands[23:16], b[7:0]);
        cdh.send(mode_seq_pkg::MSG_PANEL_START);
        cdh.send(mode_seq_pkg::MSG_TERMINATOR);
        chk({mode, slit, panel, term}, {2'h2, s[1:0], 1'b1, 1'b1});
        cdh.send(mode_seq_pkg::MSG_YAW_START);
        chk({mode, hv_on, stowed, upl}, {2'h0, 1'b0, 1'b1, 1'b1});
        cdh.send(mode_seq_pkg::MSG_YAW_END);
        chk(mode, 2'h2);
        apb(1'b1, mode_seq_pkg::OFS_SETTINGS, s);
        cdh.send(mode_seq_pkg::MSG_POWER_DOWN);
        chk({mode, hv_on, stowed}, {2'h0, 1'b0, 1'b1});
        apb(1'b1, mode_seq_pkg::OFS_MODE_CMD, 32'h00000001);
        chk({mode, raw}, {2'h1, 1'b1});
        apb(1'b0, 8'h40, 32'h00000000);
        chk(er, 1'b1);
        chk(rd, 32'h00000000);
        apb(1'b0, mode_seq_pkg::OFS_STATUS, 32'h00000000);
        chk(rd[3:0], 4'h9);
        // Sun event in mid-yaw: later yaw end must not restore
        cdh.send(mode_seq_pkg::MSG_YAW_START);
        apb(1'b1, mode_seq_pkg::OFS_RATE_LIMIT, 32'h00000000);
        repeat (8) @(posedge pclk) det_pin <= ~det_pin;
        repeat (40) @(posedge pclk);
        cdh.send(mode_seq_pkg::MSG_YAW_END);
        wait_mode(2'h0);
        chk(hv_on, 1'b0);
        apb(1'b1, mode_seq_pkg::OFS_RATE_LIMIT, 32'h0000FFFF);
        repeat (20) @(posedge pclk);
        apb(1'b1, mode_seq_pkg::OFS_MODE_CMD, 32'h00000003);
        chk(mode, 2'h3);
        wait_frame(1'b1);
        wdog_pin <= 1'b1;
        wait_mode(2'h0);
        apb(1'b1, mode_seq_pkg::OFS_MODE_CMD, 32'h00000002);
        // Controller power cycle of a silent unit lands in maintenance
        presetn <= 1'b0;
        wdog_pin <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({mode, hv_on, stowed, upl}, {2'h0, 1'b0, 1'b1, 1'b1});
        conclude();
    end
endmodule
`default_nettype wire
